// ===== rtl/mwd_decoder.sv
// Purpose: Microword format decoder with APB register access
// Assumes: Software supplies the word, current address and memory latch data
// Notes:   Results commit at the end of the machine cycle (5 or 10 clocks)
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module mwd_decoder #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr
);

  // Parameter check
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
    $error("mwd_decoder: ADDR_W must be 6 to 8");
  end

  // Field extraction, leftmost word bit is bit 0
  function automatic logic [3:0] f4(input logic [31:0] w, input int first);
    return w[31-first -: 4];
  endfunction
  function automatic logic [7:0] f8(input logic [31:0] w, input int first);
    return w[31-first -: 8];
  endfunction
  function automatic logic wb(input logic [31:0] w, input int n);
    return w[31-n];
  endfunction
  // Byte n of a fetched word, byte 0 leftmost
  function automatic logic [7:0] lbyte(input logic [31:0] w, input logic [1:0] n);
    return w[31-8*n -: 8];
  endfunction
  // Register address match
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == off[ADDR_W-1:0];
  endfunction

  // Registers
  logic [31:0] word_reg;
  logic [15:0] cur_reg;
  logic [15:0] opnd_reg;
  logic [31:0] latch_reg;
  logic [15:0] next_reg;
  logic [7:0]  bbus_reg;
  logic [15:0] daddr_reg;
  logic [7:0]  mreg [0:3];
  logic [7:0]  asrc_reg;
  logic [7:0]  ddst_reg;
  logic        busy_reg;
  logic [3:0]  cnt_reg;
  logic        sten_reg;
  logic        add_reg;
  logic        asup_reg;
  logic        dsup_reg;
  logic        dinv_reg;
  logic        special_reg;
  logic [3:0]  fmt_reg;
  logic [4:0]  spxc_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  // Decode results
  mwd_pkg::mwd_fmt_t fmt_c;
  logic        asupf_c;
  logic        dsupf_c;
  logic        special_c;
  logic [4:0]  spxc_c;
  logic [3:0]  k4_c;
  logic [7:0]  khalf_c;
  logic [7:0]  bbus_c;
  logic [15:0] next_c;
  logic [15:0] daddr_c;
  logic        sten_c;
  logic        add_c;
  logic        asup_c;
  logic        dsup_c;
  logic        dinv_c;
  logic        fetch_c;
  logic [7:0]  asrc_c;
  logic [7:0]  ddst_c;
  logic        acc;
  logic        commit;
  logic [31:0] rd_c;
  logic        map_c;

  assign acc    = psel && penable && pready_reg;
  assign commit = busy_reg && (cnt_reg == (fetch_c ? 4'(mwd_pkg::DATA_CLKS - 1)
                                                   : 4'(mwd_pkg::INSTR_CLKS - 1)));

  // Format selection and field interpretation
  always_comb begin
    asupf_c   = wb(word_reg, mwd_pkg::B_ASUP);
    dsupf_c   = wb(word_reg, mwd_pkg::B_DSUP);
    spxc_c    = word_reg[31-mwd_pkg::F_SPCODE -: 5];
    special_c = (f4(word_reg, mwd_pkg::F_CL) == mwd_pkg::CL_SPECIAL) && !asupf_c && dsupf_c;
    k4_c    = f4(word_reg, mwd_pkg::F_LO4);
    khalf_c = wb(word_reg, mwd_pkg::B_KHALF) ? {k4_c, 4'h0} : {4'h0, k4_c};
    bbus_c  = 8'h00;
    sten_c  = 1'b0;
    add_c   = 1'b0;
    asup_c  = asupf_c;
    dsup_c  = dsupf_c;
    dinv_c  = 1'b0;
    fetch_c = 1'b0;
    asrc_c  = f8(word_reg, mwd_pkg::F_AREG);
    ddst_c  = f8(word_reg, mwd_pkg::F_AREG);
    next_c  = {cur_reg[15:8], f8(word_reg, mwd_pkg::F_NEXT)};
    daddr_c = daddr_reg;
    if (asupf_c && dsupf_c) begin
      case ({wb(word_reg, mwd_pkg::B_SEL30), wb(word_reg, mwd_pkg::B_SEL31)})
        2'b11:   fmt_c = mwd_pkg::FMT_REGXFER;
        2'b01:   fmt_c = mwd_pkg::FMT_FETCH1;
        2'b00:   fmt_c = mwd_pkg::FMT_FETCH4;
        default: fmt_c = mwd_pkg::FMT_STORE;
      endcase
    end else begin
      case ({wb(word_reg, mwd_pkg::B_SEL30), wb(word_reg, mwd_pkg::B_SEL31)})
        2'b10:   fmt_c = mwd_pkg::FMT_FULLK;
        2'b00:   fmt_c = mwd_pkg::FMT_SECTOR;
        2'b11:   fmt_c = mwd_pkg::FMT_KSTAT;
        default: fmt_c = mwd_pkg::FMT_STATREG;
      endcase
    end
    case (fmt_c)
      mwd_pkg::FMT_FULLK: begin
        bbus_c = f8(word_reg, mwd_pkg::F_CONST8);
      end
      mwd_pkg::FMT_SECTOR: begin
        bbus_c       = (f4(word_reg, mwd_pkg::F_HI4) == 4'h0) ? 8'h00 : opnd_reg[15:8];
        next_c[11:8] = f4(word_reg, mwd_pkg::F_LO4);
      end
      mwd_pkg::FMT_KSTAT: begin
        bbus_c = khalf_c;
        sten_c = 1'b1;
      end
      mwd_pkg::FMT_STATREG: begin
        bbus_c = (k4_c == 4'h0) ? 8'h00 : opnd_reg[15:8];
        sten_c = 1'b1;
      end
      mwd_pkg::FMT_REGXFER: begin
        bbus_c = (f4(word_reg, mwd_pkg::F_CB5) == 4'h0) ? 8'h00 : opnd_reg[15:8];
        ddst_c = f8(word_reg, mwd_pkg::F_CONST8);
        asup_c = (asrc_c == 8'h00);
        dsup_c = (ddst_c == 8'h00);
        dinv_c = (ddst_c > mwd_pkg::DEST_MAX);
      end
      mwd_pkg::FMT_FETCH1: begin
        asup_c  = 1'b1;
        dsup_c  = 1'b1;
        fetch_c = 1'b1;
        daddr_c = {daddr_reg[15:12], f4(word_reg, mwd_pkg::F_HI4), opnd_reg[7:0]};
      end
      mwd_pkg::FMT_FETCH4: begin
        bbus_c  = khalf_c;
        add_c   = 1'b1;
        fetch_c = 1'b1;
        daddr_c = {daddr_reg[15:12], f4(word_reg, mwd_pkg::F_HI4), opnd_reg[7:0]};
      end
      default: begin
        asup_c = 1'b1;
        dsup_c = 1'b1;
      end
    endcase
    if (special_c) begin
      add_c  = 1'b1;
      asup_c = 1'b1;
      dsup_c = 1'b1;
      if (spxc_c == mwd_pkg::SPC_QUAD) begin
        daddr_c[14:12] = bbus_c[2:0];
      end
      if (spxc_c == mwd_pkg::SPC_INSTR) begin
        next_c[14:8] = bbus_c[6:0];
      end
    end
  end

  // Machine cycle sequencer, a new word is ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 4'h0;
    end else if (commit) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 4'h0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else if (acc && pwrite && hit(paddr, mwd_pkg::OFF_WORD)) begin
      busy_reg <= 1'b1;
    end
  end

  // Software-written word and operands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg  <= mwd_pkg::RST_WORD;
      opnd_reg  <= mwd_pkg::RST_ADDR;
      latch_reg <= mwd_pkg::RST_WORD;
    end else if (acc && pwrite) begin
      if (hit(paddr, mwd_pkg::OFF_WORD) && !busy_reg) begin
        word_reg <= pwdata;
      end
      if (hit(paddr, mwd_pkg::OFF_OPND)) begin
        opnd_reg <= pwdata[15:0];
      end
      if (hit(paddr, mwd_pkg::OFF_LATCH)) begin
        latch_reg <= pwdata;
      end
    end
  end

  // Current address: committed next address wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= mwd_pkg::RST_ADDR;
    end else if (commit) begin
      cur_reg <= next_c;
    end else if (acc && pwrite && hit(paddr, mwd_pkg::OFF_CUR)) begin
      cur_reg <= pwdata[15:0];
    end
  end

  // Decode results latched at end of machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_reg <= mwd_pkg::RST_ADDR;
      bbus_reg <= 8'h00;
      daddr_reg <= mwd_pkg::RST_ADDR;
      asrc_reg <= 8'h00;
      ddst_reg <= 8'h00;
      sten_reg <= 1'b0;
      add_reg  <= 1'b0;
      asup_reg <= 1'b0;
      dsup_reg <= 1'b0;
      dinv_reg <= 1'b0;
      special_reg <= 1'b0;
      fmt_reg  <= 4'h0;
      spxc_reg <= 5'h00;
    end else if (commit) begin
      next_reg <= next_c;
      bbus_reg <= bbus_c;
      daddr_reg <= daddr_c;
      asrc_reg <= asrc_c;
      ddst_reg <= ddst_c;
      sten_reg <= sten_c;
      add_reg  <= add_c;
      asup_reg <= asup_c;
      dsup_reg <= dsup_c;
      dinv_reg <= dinv_c;
      special_reg <= special_c;
      fmt_reg  <= 4'(fmt_c);
      spxc_reg <= spxc_c;
    end
  end

  // Memory byte 0: selected byte on either fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mreg[0] <= 8'h00;
    end else if (commit && fetch_c) begin
      mreg[0] <= lbyte(latch_reg, daddr_c[1:0]);
    end
  end

  // Memory bytes 1 to 3: straight copy on four-byte fetch
  for (genvar i = 1; i < 4; i++) begin : g_mreg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mreg[i] <= 8'h00;
      end else if (commit && fmt_c == mwd_pkg::FMT_FETCH4) begin
        mreg[i] <= lbyte(latch_reg, 2'(i));
      end
    end
  end

  // Read data selection
  always_comb begin
    map_c = 1'b1;
    rd_c  = 32'h0000_0000;
    if (hit(paddr, mwd_pkg::OFF_WORD)) begin
      rd_c = word_reg;
    end else if (hit(paddr, mwd_pkg::OFF_CUR)) begin
      rd_c[15:0] = cur_reg;
    end else if (hit(paddr, mwd_pkg::OFF_OPND)) begin
      rd_c[15:0] = opnd_reg;
    end else if (hit(paddr, mwd_pkg::OFF_LATCH)) begin
      rd_c = latch_reg;
    end else if (hit(paddr, mwd_pkg::OFF_STAT)) begin
      rd_c[mwd_pkg::ST_BUSY]        = busy_reg;
      rd_c[mwd_pkg::ST_STEN]        = sten_reg;
      rd_c[mwd_pkg::ST_ADD]         = add_reg;
      rd_c[mwd_pkg::ST_ASUP]        = asup_reg;
      rd_c[mwd_pkg::ST_DSUP]        = dsup_reg;
      rd_c[mwd_pkg::ST_DINV]        = dinv_reg;
      rd_c[mwd_pkg::ST_SPECIAL]     = special_reg;
      rd_c[mwd_pkg::ST_FMT +: 4]    = fmt_reg;
      rd_c[mwd_pkg::ST_SPXC +: 5]   = spxc_reg;
    end else if (hit(paddr, mwd_pkg::OFF_NEXT)) begin
      rd_c[15:0] = next_reg;
    end else if (hit(paddr, mwd_pkg::OFF_BBUS)) begin
      rd_c[7:0] = bbus_reg;
    end else if (hit(paddr, mwd_pkg::OFF_DADDR)) begin
      rd_c[15:0] = daddr_reg;
    end else if (hit(paddr, mwd_pkg::OFF_MREG)) begin
      rd_c = {mreg[0], mreg[1], mreg[2], mreg[3]};
    end else if (hit(paddr, mwd_pkg::OFF_AD)) begin
      rd_c[15:0] = {asrc_reg, ddst_reg};
    end else begin
      map_c = 1'b0;
    end
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !map_c;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_c;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_plain_start;
    $rose(busy_reg) && !fetch_c;
  endsequence
  sequence s_fetch_start;
    $rose(busy_reg) && fetch_c;
  endsequence

  property p_fullk;
    commit && fmt_c == mwd_pkg::FMT_FULLK |=> bbus_reg == $past(word_reg[31:24]) && !sten_reg;
  endproperty
  a_fullk: assert property (p_fullk) else $error("full constant not on B bus");

  property p_next_hi;
    commit && fmt_c != mwd_pkg::FMT_SECTOR && !(special_c && spxc_c == mwd_pkg::SPC_INSTR)
      |=> next_reg[15:8] == $past(cur_reg[15:8]);
  endproperty
  a_next_hi: assert property (p_next_hi) else $error("next address high chars changed");

  property p_sector;
    commit && fmt_c == mwd_pkg::FMT_SECTOR && !special_c
      |=> next_reg[15:12] == $past(cur_reg[15:12]) && next_reg[11:8] == $past(word_reg[27:24]) && !sten_reg;
  endproperty
  a_sector: assert property (p_sector) else $error("sector switch address wrong");

  property p_khigh;
    commit && fmt_c == mwd_pkg::FMT_KSTAT && word_reg[12] |=> bbus_reg[3:0] == 4'h0 && sten_reg;
  endproperty
  a_khigh: assert property (p_khigh) else $error("high constant half misplaced");

  property p_regxfer;
    commit && fmt_c == mwd_pkg::FMT_REGXFER |=> !sten_reg && dinv_reg == ($past(word_reg[31:24]) > 8'h0F);
  endproperty
  a_regxfer: assert property (p_regxfer) else $error("register transfer check wrong");

  property p_byte_sel;
    commit && fmt_c == mwd_pkg::FMT_FETCH1 |=> mreg[0] == lbyte($past(latch_reg), $past(opnd_reg[1:0]));
  endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("wrong byte in byte0 register");

  property p_quad;
    commit && !(special_c && spxc_c == mwd_pkg::SPC_QUAD) |=> $stable(daddr_reg[15:12]);
  endproperty
  a_quad: assert property (p_quad) else $error("quadrant changed without 04");

  property p_plain_time;
    s_plain_start |-> busy_reg [*5] ##1 !busy_reg;
  endproperty
  a_plain_time: assert property (p_plain_time) else $error("plain word not 5 clocks");

  property p_fetch_time;
    s_fetch_start |-> busy_reg [*8] ##1 busy_reg [*2] ##1 !busy_reg;
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("fetch word not 10 clocks");

endmodule // mwd_decoder

// ===== rtl/mwd_pkg.sv
// Purpose: Constants and types for the microword format decoder
// Assumes: Word bit 0 is the most significant bit of a 32-bit microword
// Notes:   Field positions count from that leftmost bit
package mwd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_WORD  = 8'h00;
  localparam logic [7:0] OFF_CUR   = 8'h04;
  localparam logic [7:0] OFF_OPND  = 8'h08;
  localparam logic [7:0] OFF_LATCH = 8'h0C;
  localparam logic [7:0] OFF_STAT  = 8'h10;
  localparam logic [7:0] OFF_NEXT  = 8'h14;
  localparam logic [7:0] OFF_BBUS  = 8'h18;
  localparam logic [7:0] OFF_DADDR = 8'h1C;
  localparam logic [7:0] OFF_MREG  = 8'h20;
  localparam logic [7:0] OFF_AD    = 8'h24;
  // Microword field positions (leftmost bit of field)
  localparam int F_CONST8 = 0;
  localparam int F_HI4    = 0;
  localparam int F_LO4    = 4;
  localparam int F_AREG   = 8;
  localparam int F_SPCODE = 11;
  localparam int F_CB5    = 16;
  localparam int B_KHALF  = 19;
  localparam int F_NEXT   = 20;
  localparam int F_CL     = 24;
  localparam int B_ASUP   = 28;
  localparam int B_DSUP   = 29;
  localparam int B_SEL30  = 30;
  localparam int B_SEL31  = 31;
  // Decode values
  localparam logic [3:0] CL_SPECIAL = 4'hF;
  localparam logic [4:0] SPC_QUAD   = 5'h04;
  localparam logic [4:0] SPC_INSTR  = 5'h05;
  localparam logic [7:0] DEST_MAX  = 8'h0F;
  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_STEN = 1;
  localparam int ST_ADD  = 2;
  localparam int ST_ASUP = 3;
  localparam int ST_DSUP = 4;
  localparam int ST_DINV = 5;
  localparam int ST_SPECIAL = 6;
  localparam int ST_FMT  = 8;
  localparam int ST_SPXC = 12;
  // Reset values
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Machine timing
  localparam int CLK_NS     = 40;
  localparam int CYCLE_NS   = 200;
  localparam int DATA_NS    = 400;
  localparam int INSTR_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_CLKS  = (DATA_NS + CLK_NS - 1) / CLK_NS;
  // Word formats
  typedef enum logic [3:0] {
    FMT_SECTOR, FMT_FULLK, FMT_STATREG, FMT_KSTAT,
    FMT_REGXFER, FMT_FETCH1, FMT_FETCH4, FMT_STORE
  } mwd_fmt_t;
endpackage

// ===== dv/mwd_store_model.sv
// Purpose: Control store model with test microwords and a data word
// Assumes: Words keep the microprogram coding limits
// Notes:   Pure table; the bench loads each word into the decoder
`timescale 1ns/1ns
module mwd_store_model (
  // Store contents
  output logic [9:0][31:0] words,
  output logic [31:0]      data_word
);
  // Suppress-field words: pair never 11, A/D field left unused
  assign words[0] = 32'hA500_03CA;
  assign words[1] = 32'h3900_05D4;
  assign words[2] = 32'h0900_05D0;
  // Four-bit constants keep one half of the B value zero; third word puts the operand high byte on B
  assign words[3] = 32'h6B00_0213;
  assign words[4] = 32'h6B00_1217;
  assign words[5] = 32'h5200_0449;
  // Register transfers (second one names a bad destination), then fetches
  assign words[6] = 32'h0E31_077F;
  assign words[7] = 32'h1031_077F;
  assign words[8] = 32'h2000_0A5D;
  assign words[9] = 32'h2000_0A5C;
  // Data word sitting in the memory latches
  assign data_word = 32'h1122_3344;
endmodule // mwd_store_model

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the microword format decoder
// Assumes: APB master leaves one idle cycle after each transfer
// Notes:   Expected values come from the word fields, operand, current address and data word
`timescale 1ns/1ns
module tb_top;
  // Clock, reset and APB
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Store model and bookkeeping
  logic [9:0][31:0] words;
  logic [31:0]      data_word;
  logic [31:0]      rd;
  logic             er;
  int               err_total;
  int               total_checks;
  int               cyc;
  int               t_end;
  logic [3:0] e_fmt [10] = '{4'h1, 4'h0, 4'h0, 4'h3, 4'h3, 4'h2, 4'h4, 4'h4, 4'h5, 4'h6};
  logic [7:0] e_bb [10] = '{8'hA5, 8'hC4, 8'h00, 8'h0B, 8'hB0, 8'hC4, 8'h00, 8'h00, 8'h00, 8'h00};

  mwd_decoder #(.ADDR_W(8)) mwd_decoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  mwd_store_model mwd_store_model_inst (.words(words), .data_word(data_word));

  // Clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Masked compare
  task automatic chk(input logic [31:0] got, input logic [31:0] m, input logic [31:0] exp, input string s);
    total_checks++;
    if ((got & m) !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got & m, exp);
    end
  endtask

  // One APB transfer, then an idle cycle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    t_end = cyc;
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, 32'h1, "no ready");
      report_and_stop();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // Load a word, optionally hit it while busy, wait for the commit
  task automatic run(input logic [31:0] w, input logic dup);
    int   t0;
    int   n;
    logic ok;
    xfer(1'b1, mwd_pkg::OFF_WORD, w);
    t0 = t_end;
    if (dup) xfer(1'b1, mwd_pkg::OFF_WORD, words[6]);
    n = 0;
    do begin
      xfer(1'b0, mwd_pkg::OFF_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) begin
      chk(32'h0, 32'h1, 32'h1, "stuck busy");
      report_and_stop();
    end else begin
      ok = (w[3:1] == 3'b110) ? (t_end - t0 inside {[11:14]}) : (t_end - t0 inside {[6:9]});
      chk({31'h0, ok}, 32'h1, 32'h1, "busy span");
    end
  endtask

  // Main sequence
  initial begin
    logic [31:0] w;
    logic [31:0] sm;
    logic [31:0] se;
    logic [15:0] nx;
    logic [7:0]  a;
    logic [3:0]  f;
    logic [5:0]  c;
    logic [2:0]  s;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped offset, read-only write
    for (a = 8'h00; a < 8'h28; a = a + 8'h04) begin
      xfer(1'b0, a, 32'h0);
      chk(rd, 32'hFFFF_FFFF, 32'h0, "reset value");
    end
    xfer(1'b0, 8'h28, 32'h0);
    chk({31'h0, er}, 32'h1, 32'h1, "unmapped error");
    xfer(1'b1, mwd_pkg::OFF_NEXT, 32'hFFFF);
    xfer(1'b0, mwd_pkg::OFF_NEXT, 32'h0);
    chk(rd, 32'hFFFF, 32'h0, "read-only write");
    $display("Test registers done");
    // Every word format except store; first word also rewritten while busy
    xfer(1'b1, mwd_pkg::OFF_OPND, 32'hC42B);
    xfer(1'b1, mwd_pkg::OFF_LATCH, data_word);
    for (int i = 0; i < 10; i++) begin
      w = words[i];
      f = e_fmt[i];
      xfer(1'b1, mwd_pkg::OFF_CUR, 32'h7E11);
      run(w, i == 0);
      xfer(1'b0, mwd_pkg::OFF_STAT, 32'h0);
      sm = 32'h0F45 | (f < 5 ? 32'h2 : 32'h0) | (f < 4 ? 32'h18 : 32'h0) | (f == 4 ? 32'h20 : 32'h0);
      se = {20'h0, f, 2'b00, f == 4 && w[31:24] > 8'h0F, w[2], w[3], f == 6, f == 2 || f == 3, 1'b0};
      chk(rd, sm, se & sm, "status");
      nx = (f == 4'h0) ? {4'h7, w[27:24], w[11:4]} : {8'h7E, w[11:4]};
      xfer(1'b0, mwd_pkg::OFF_NEXT, 32'h0);
      chk(rd, 32'hFFFF, {16'h0, nx}, "next address");
      xfer(1'b0, mwd_pkg::OFF_CUR, 32'h0);
      chk(rd, 32'hFFFF, {16'h0, nx}, "current address");
      xfer(1'b0, mwd_pkg::OFF_BBUS, 32'h0);
      if (f < 5) chk(rd, 32'hFF, {24'h0, e_bb[i]}, "b bus");
      xfer(1'b0, mwd_pkg::OFF_AD, 32'h0);
      if (i == 6) chk(rd, 32'hFFFF, {16'h0, w[23:16], w[31:24]}, "a and d");
      xfer(1'b0, mwd_pkg::OFF_DADDR, 32'h0);
      if (f > 4) chk(rd, 32'hFFFF, {16'h0, 4'h0, w[31:28], 8'h2B}, "data address");
      xfer(1'b0, mwd_pkg::OFF_MREG, 32'h0);
      if (f == 5) chk(rd, 32'hFF00_0000, 32'h4400_0000, "byte fetch");
      if (f == 6) chk(rd, 32'hFFFF_FFFF, 32'h4422_3344, "word fetch");
    end
    $display("Test formats done");
    // All special-execute codes; code 04 loads the quadrant
    for (c = 6'd0; c < 6'd32; c++) begin
      run(32'h0500_00F6 | {11'h0, c[4:0], 16'h0}, 1'b0);
      xfer(1'b0, mwd_pkg::OFF_STAT, 32'h0);
      chk(rd, 32'h0001_FF40, {15'h0, c[4:0], 4'h1, 8'h40}, "special code");
      xfer(1'b0, mwd_pkg::OFF_DADDR, 32'h0);
      if (c == 6'd4) chk(rd, 32'hF000, 32'h5000, "quadrant load");
    end
    $display("Test special done");
    // Byte selection by low data address bits; quadrant kept
    for (s = 3'd0; s < 3'd4; s++) begin
      xfer(1'b1, mwd_pkg::OFF_OPND, 32'hC428 | {30'h0, s[1:0]});
      run(words[8], 1'b0);
      xfer(1'b0, mwd_pkg::OFF_DADDR, 32'h0);
      chk(rd, 32'hFFFF, {16'h0, 8'h52, 6'h0A, s[1:0]}, "fetch address");
      xfer(1'b0, mwd_pkg::OFF_MREG, 32'h0);
      chk(rd, 32'hFF00_0000, {data_word[31 - 8 * s[1:0] -: 8], 24'h0}, "byte select");
    end
    $display("Test byte select done");
    report_and_stop();
  end
endmodule // tb_top
